// ---- hw/disk_controller.sv ----
// command decode, condition flags, dma channel and serial data of the disk controller
// Functional notes
// RULE1: the host reaches the block only by command transfers, the interrupt and dma cycles.
// RULE2: six commands are decoded (query, seek, write, read, verify, format) and acted on.
// RULE3: an interrupt is raised on command completion, on abort and on seek finish.
// RULE4: after an interrupt the host issues a condition query to learn the cause.
// RULE5: the condition query returns eight flags from done through data overrun.
// RULE6: per word the address counts up, the word count down, and the block ends at zero.
// RULE7: the serial bit stream is followed without loss and a lost word reports overrun.
// RULE8: one of up to four daisy-chained drives is selected.
// RULE9: data words and command parameters move by dma cycles. Here the parameter word is written over apb to ADDR_PARAM instead.
// RULE10: the command is latched and the next write word is buffered ahead of need.
// RULE11: flags stay set until a condition query, which also clears the interrupt request.
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module disk_controller
  import disk_ctrl_pkg::*;
  #(parameter int NUM_DRIVES = 4)
  (
  input wire logic pclk, // clock, 200 MHz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  output logic irq, // interrupt, level
  output dma_req_s dma_req, // dma request
  input wire dma_rsp_s dma_rsp, // dma answer
  output logic [NUM_DRIVES-1:0] drive_select, // drive select lines
  output logic drive_seek, // seek strobe to drive
  output logic [7:0] drive_cylinder, // seek cylinder
  output logic drive_write_gate, // write enable to drive
  output logic drive_write_bit, // serial write data
  input wire logic drive_ready, // selected drive ready, pin
  input wire logic drive_seek_done, // seek complete, pin
  input wire logic drive_fault, // drive fault, pin
  input wire logic drive_bit_strobe, // bit clock pulse level, pin
  input wire logic drive_read_bit // serial read data, pin
  );

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [4:0] pins_sync;
  logic ready_s, seek_done_s, fault_s, strobe_s, rbit_s;
  logic strobe_d, seek_done_d;
  logic bit_tick, seek_rise;

  sync2 #(.WIDTH(5)) u_sync
  (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({drive_ready, drive_seek_done, drive_fault, drive_bit_strobe, drive_read_bit}),
    .sync_out(pins_sync)
  );

  assign {ready_s, seek_done_s, fault_s, strobe_s, rbit_s} = pins_sync;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      strobe_d <= 1'b0;
      seek_done_d <= 1'b0;
    end
    else
    begin
      strobe_d <= strobe_s;
      seek_done_d <= seek_done_s;
    end
  end

  assign bit_tick = strobe_s & ~strobe_d;
  assign seek_rise = seek_done_s & ~seek_done_d;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  logic apb_wr, apb_rd, addr_ok;
  logic [31:0] next_prdata;

  assign apb_wr = psel & penable & pwrite & pready;
  assign apb_rd = psel & penable & ~pwrite & pready;

  ctrl_state_e state;
  logic [15:0] cmd_latch;
  logic [15:0] param;
  logic [7:0] flags;
  logic [2:0] irq_status;
  logic [2:0] irq_mask;
  logic [15:0] mem_addr;
  logic [15:0] word_count;
  logic [15:0] wbuf;
  logic wbuf_full;
  logic [15:0] rd_word;
  logic [15:0] shifter;
  logic [4:0] bit_cnt;
  logic shifter_full;
  logic cmd_go, query_go;
  opcode_e op;

  assign op = opcode_e'(cmd_latch[CMD_OP_LSB +: 3]);

  // RULE1 commands only by bus transfer
  assign cmd_go = apb_wr && paddr == ADDR_COMMAND && state == ST_IDLE;
  // RULE4 query read by the host
  assign query_go = apb_rd && paddr == ADDR_CONDITION;

  always_comb
  begin
    addr_ok = 1'b1;
    next_prdata = 32'h0000_0000;
    case (paddr)
      ADDR_COMMAND: next_prdata = {16'h0000, cmd_latch};
      ADDR_PARAM: next_prdata = {16'h0000, param};
      // RULE5 eight condition flags
      ADDR_CONDITION: next_prdata = {24'h000000, flags};
      ADDR_MEM_ADDR: next_prdata = {16'h0000, mem_addr};
      ADDR_WORD_COUNT: next_prdata = {16'h0000, word_count};
      ADDR_IRQ_STATUS: next_prdata = {29'h0000000, irq_status};
      ADDR_IRQ_MASK: next_prdata = {29'h0000000, irq_mask};
      ADDR_WRITE_DATA: next_prdata = {16'h0000, wbuf};
      ADDR_READ_DATA: next_prdata = {16'h0000, rd_word};
      ADDR_STATE: next_prdata = {30'h00000000, state == ST_IDLE ? 2'h0 :
                                 state == ST_SEEK ? 2'h1 : state == ST_XFER ? 2'h2 : 2'h3};
      default: addr_ok = 1'b0;
    endcase
  end

  // no wait state: pready raised by the setup cycle, high in the first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & ~penable;
      if (psel && !penable)
      begin
        prdata <= next_prdata;
        pslverr <= ~addr_ok;
      end
      else if (pready)
        pslverr <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command latch and parameters
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd_latch <= WORD_RESET;
      param <= WORD_RESET;
      irq_mask <= IRQ_MASK_RESET;
    end
    else
    begin
      // RULE10 command latched
      if (cmd_go)
        cmd_latch <= pwdata[15:0];
      // RULE9 parameter written by apb transfer here, not by a dma cycle
      if (apb_wr && paddr == ADDR_PARAM)
        param <= pwdata[15:0];
      if (apb_wr && paddr == ADDR_IRQ_MASK)
        irq_mask <= pwdata[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  logic ev_complete, ev_abort;
  logic xfer_word_done;
  logic overrun_ev;
  logic is_write_op;

  assign is_write_op = (op == OP_WRITE) || (op == OP_FORMAT);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= ST_IDLE;
    else
    begin
      case (state)
        ST_IDLE:
          if (cmd_go)
            state <= ST_FINISH;
        ST_SEEK:
          if (seek_rise || fault_s)
            state <= ST_IDLE;
        ST_XFER:
          // at zero count, write ops end only once the last buffered word has left the shifter
          if ((word_count == WORD_RESET && (!is_write_op || (!wbuf_full && bit_cnt == 5'd0)))
              || overrun_ev || fault_s)
            state <= ST_FINISH;
        ST_FINISH:
          // a finished or cut transfer never restarts
          if (from_xfer)
            state <= ST_IDLE;
          else
          begin
            // RULE2 dispatch on the latched opcode
            case (op)
              OP_SEEK: state <= (ready_s && !fault_s) ? ST_SEEK : ST_IDLE;
              OP_WRITE, OP_READ, OP_VERIFY, OP_FORMAT:
                state <= (ready_s && !fault_s && word_count != WORD_RESET && bit_cnt == 5'd0)
                         ? ST_XFER : ST_IDLE;
              default: state <= ST_IDLE;
            endcase
          end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // finish state entered from transfer marks end of block
  logic from_xfer;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      from_xfer <= 1'b0;
    else
      from_xfer <= (state == ST_XFER);
  end

  // RULE3 completion and abort events
  assign ev_complete = (state == ST_FINISH && from_xfer && flags[FLAG_OVERRUN] == 1'b0
                        && !fault_s)
                       || (state == ST_FINISH && !from_xfer && op == OP_CONDITION_QUERY);
  assign ev_abort = (state == ST_FINISH && !from_xfer && op != OP_CONDITION_QUERY
                     && (!ready_s || fault_s || op == OP_RSVD6 || op == OP_RSVD7))
                    || (state == ST_FINISH && from_xfer && (flags[FLAG_OVERRUN] || fault_s));

  ////////////////////////////////////////////////////////////////////////////
  // drive selection and seek
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      drive_select <= '0;
      drive_seek <= 1'b0;
      drive_cylinder <= 8'h00;
    end
    else
    begin
      // RULE8 one of four drives
      if (cmd_go)
        drive_select <= NUM_DRIVES'(1) << pwdata[CMD_DRIVE_LSB +: 2];
      drive_seek <= state == ST_FINISH && !from_xfer && op == OP_SEEK && ready_s;
      if (cmd_go)
        drive_cylinder <= pwdata[CMD_CYL_LSB +: 8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // dma channel and serial data
  logic dma_busy;
  assign xfer_word_done = dma_rsp.ack & dma_busy;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mem_addr <= WORD_RESET;
      word_count <= WORD_RESET;
      dma_req <= '0;
      dma_busy <= 1'b0;
      wbuf <= WORD_RESET;
      wbuf_full <= 1'b0;
      rd_word <= WORD_RESET;
    end
    else
    begin
      if (state == ST_IDLE && apb_wr && paddr == ADDR_MEM_ADDR)
        mem_addr <= pwdata[15:0];
      if (state == ST_IDLE && apb_wr && paddr == ADDR_WORD_COUNT)
        word_count <= pwdata[15:0];
      if (xfer_word_done)
      begin
        dma_busy <= 1'b0;
        dma_req.req <= 1'b0;
        // RULE6 address up, count down
        mem_addr <= mem_addr + 16'h0001;
        word_count <= word_count - 16'h0001;
        // RULE10 next write word buffered
        if (!dma_req.wr)
        begin
          wbuf <= dma_rsp.rdata;
          wbuf_full <= 1'b1;
        end
      end
      else if (!dma_busy && state == ST_XFER && word_count != WORD_RESET)
      begin
        // RULE9 data by dma cycles
        if (is_write_op && !wbuf_full)
        begin
          dma_req <= '{req: 1'b1, wr: 1'b0, addr: mem_addr, wdata: WORD_RESET};
          dma_busy <= 1'b1;
        end
        else if (!is_write_op && shifter_full)
        begin
          dma_req <= '{req: 1'b1, wr: (op == OP_READ), addr: mem_addr, wdata: shifter};
          dma_busy <= 1'b1;
          rd_word <= shifter;
        end
      end
      if (state == ST_XFER && is_write_op && bit_tick && bit_cnt == 5'd0 && wbuf_full)
        wbuf_full <= 1'b0;
      if (state == ST_IDLE)
        wbuf_full <= 1'b0;
    end
  end

  // RULE7 bit shifter follows the stream
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      shifter <= WORD_RESET;
      bit_cnt <= 5'd0;
      shifter_full <= 1'b0;
      drive_write_gate <= 1'b0;
      drive_write_bit <= 1'b0;
    end
    else
    begin
      drive_write_gate <= state == ST_XFER && is_write_op;
      if (state != ST_XFER)
      begin
        bit_cnt <= 5'd0;
        shifter_full <= 1'b0;
      end
      else if (bit_tick)
      begin
        if (is_write_op)
        begin
          if (bit_cnt == 5'd0)
            shifter <= wbuf;
          else
            shifter <= {1'b0, shifter[15:1]};
          drive_write_bit <= (bit_cnt == 5'd0) ? wbuf[0] : shifter[1];
        end
        else
          shifter <= {rbit_s, shifter[15:1]};
        bit_cnt <= (bit_cnt == 5'(WORD_BITS - 1)) ? 5'd0 : bit_cnt + 5'd1;
        if (!is_write_op && bit_cnt == 5'(WORD_BITS - 1))
          shifter_full <= 1'b1;
      end
      else if (xfer_word_done && !is_write_op)
        shifter_full <= 1'b0;
    end
  end

  // word lost when a new word starts while the last is still unserved
  assign overrun_ev = state == ST_XFER && bit_tick && bit_cnt == 5'd0 &&
                      (is_write_op ? (!wbuf_full && word_count != WORD_RESET) : shifter_full);

  ////////////////////////////////////////////////////////////////////////////
  // condition flags and interrupt
  logic [7:0] flag_set;
  logic [2:0] irq_set;
  logic verify_miss;

  assign verify_miss = xfer_word_done && op == OP_VERIFY && dma_rsp.rdata != shifter;

  always_comb
  begin
    flag_set = 8'h00;
    flag_set[FLAG_DONE] = ev_complete;
    flag_set[FLAG_MALFUNCTION] = fault_s && state != ST_IDLE;
    flag_set[FLAG_NOT_READY] = state == ST_FINISH && !from_xfer && !ready_s
                               && op != OP_CONDITION_QUERY;
    flag_set[FLAG_SEEK_CHANGE] = seek_rise;
    flag_set[FLAG_PROGRAM_ERR] = state == ST_FINISH && !from_xfer
                                 && (op == OP_RSVD6 || op == OP_RSVD7);
    flag_set[FLAG_ADDRESS_ERR] = xfer_word_done && mem_addr == 16'hFFFF && word_count != 16'h0001;
    flag_set[FLAG_DATA_ERR] = verify_miss;
    flag_set[FLAG_OVERRUN] = overrun_ev;
    irq_set = {seek_rise, ev_abort, ev_complete};
  end

  // RULE11 flags held until query, set wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flags <= FLAGS_RESET;
    else if (query_go)
      flags <= flag_set;
    else
      flags <= flags | flag_set;
  end

  // RULE3 sticky interrupt causes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_status <= 3'h0;
      irq <= 1'b0;
    end
    else
    begin
      // RULE11 query clears request
      if (query_go)
        irq_status <= irq_set;
      else if (apb_wr && paddr == ADDR_IRQ_STATUS)
        irq_status <= (irq_status & ~pwdata[2:0]) | irq_set;
      else
        irq_status <= irq_status | irq_set;
      irq <= |(irq_status & irq_mask);
    end
  end

endmodule : disk_controller
`default_nettype wire

// ---- hw/disk_ctrl_pkg.sv ----
// shared constants and types of the disk controller command/status block
package disk_ctrl_pkg;

  // apb register byte offsets
  localparam logic [7:0] ADDR_COMMAND = 8'h00;
  localparam logic [7:0] ADDR_PARAM = 8'h04;
  localparam logic [7:0] ADDR_CONDITION = 8'h08;
  localparam logic [7:0] ADDR_MEM_ADDR = 8'h0C;
  localparam logic [7:0] ADDR_WORD_COUNT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
  localparam logic [7:0] ADDR_WRITE_DATA = 8'h1C;
  localparam logic [7:0] ADDR_READ_DATA = 8'h20;
  localparam logic [7:0] ADDR_STATE = 8'h24;

  // command field positions
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_DRIVE_LSB = 4;
  localparam int CMD_CYL_LSB = 8;

  // condition flag positions
  localparam int FLAG_DONE = 0;
  localparam int FLAG_MALFUNCTION = 1;
  localparam int FLAG_NOT_READY = 2;
  localparam int FLAG_SEEK_CHANGE = 3;
  localparam int FLAG_PROGRAM_ERR = 4;
  localparam int FLAG_ADDRESS_ERR = 5;
  localparam int FLAG_DATA_ERR = 6;
  localparam int FLAG_OVERRUN = 7;

  // interrupt status bit positions
  localparam int IRQ_COMPLETE = 0;
  localparam int IRQ_ABORT = 1;
  localparam int IRQ_SEEK_DONE = 2;

  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  // serial link: 16-bit word, one bit per bit strobe
  localparam int WORD_BITS = 16;

  typedef enum logic [2:0] {
    OP_CONDITION_QUERY,
    OP_SEEK,
    OP_WRITE,
    OP_READ,
    OP_VERIFY,
    OP_FORMAT,
    OP_RSVD6,
    OP_RSVD7
  } opcode_e;

  typedef enum {
    ST_IDLE,
    ST_SEEK,
    ST_XFER,
    ST_FINISH
  } ctrl_state_e;

  typedef struct packed {
    logic req;
    logic wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } dma_req_s;

  typedef struct packed {
    logic ack;
    logic [15:0] rdata;
  } dma_rsp_s;

endpackage : disk_ctrl_pkg

// ---- hw/sync2.sv ----
// two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
`default_nettype none
module sync2
  #(parameter int WIDTH = 1)
  (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, active low
  input wire logic [WIDTH-1:0] async_in, // pins
  output logic [WIDTH-1:0] sync_out // synchronised
  );

  logic [WIDTH-1:0] meta;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule : sync2
`default_nettype wire

// ---- verification/disk_controller_bench.sv ----
// self-checking bench of the disk controller
`timescale 1ns/1ps
`default_nettype none
module disk_controller_bench
  import disk_ctrl_pkg::*;
  ;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, irq, err, drive_seek, drive_write_gate, drive_write_bit;
  logic drive_ready = 1'b1, drive_seek_done = 1'b0, drive_fault = 1'b0;
  logic drive_bit_strobe = 1'b0, drive_read_bit = 1'b0;
  logic [3:0] drive_select, seek_sel;
  logic [7:0] drive_cylinder, seek_cyl, cyl;
  logic [15:0] last_fetch, base, w0, w1, wbits;
  dma_req_s dma_req;
  dma_rsp_s dma_rsp;
  int fails = 0, n_compared = 0, n_seek = 0, i, k;
  opcode_e ops [3] = '{OP_WRITE, OP_VERIFY, OP_FORMAT};
  always #2.5 pclk = ~pclk;
  always @(negedge pclk)
    if (drive_seek === 1'b1)
    begin
      seek_sel = drive_select;
      seek_cyl = drive_cylinder;
      n_seek++;
    end
  disk_controller uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .dma_req(dma_req), .dma_rsp(dma_rsp),
    .drive_select(drive_select), .drive_seek(drive_seek), .drive_cylinder(drive_cylinder),
    .drive_write_gate(drive_write_gate), .drive_write_bit(drive_write_bit),
    .drive_ready(drive_ready), .drive_seek_done(drive_seek_done), .drive_fault(drive_fault),
    .drive_bit_strobe(drive_bit_strobe), .drive_read_bit(drive_read_bit));
  host_mem_model mem_i (.pclk(pclk), .presetn(presetn), .dma_req(dma_req),
    .dma_rsp(dma_rsp), .last_fetch(last_fetch));
  ////////////////////////////////////////////////////////////////////////////////
  task final_report;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      fails++;
    end
  endtask : chk
  task need(input logic ok);
    if (ok !== 1'b1)
    begin
      fails++;
      final_report();
    end
  endtask : need
  task apb(input logic w, input logic [7:0] a, input logic [31:0] dt);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dt;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 16);
    need(pready);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] dt);
    apb(1'b1, a, dt);
  endtask : wr
  task rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdchk
  task wait_irq;
    for (k = 0; k < 4000 && irq !== 1'b1; k++)
      @(negedge pclk);
    need(irq);
  endtask : wait_irq
  task send_word(input logic [15:0] w);
    for (int b = 0; b < WORD_BITS; b++)
    begin
      @(posedge pclk);
      drive_read_bit <= w[b];
      drive_bit_strobe <= 1'b1;
      repeat (40) @(posedge pclk);
      wbits = {drive_write_bit, wbits[15:1]};
      drive_bit_strobe <= 1'b0;
      repeat (39) @(posedge pclk);
    end
  endtask : send_word
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h5b96));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(ADDR_CONDITION, {24'h0, FLAGS_RESET});
    rdchk(ADDR_IRQ_MASK, {29'h0, IRQ_MASK_RESET});
    rdchk(ADDR_WORD_COUNT, {16'h0, WORD_RESET});
    rdchk(8'h3C, 32'h0);
    chk({31'h0, err}, 32'h1);
    wr(ADDR_COMMAND, 32'(OP_CONDITION_QUERY));
    repeat (8) @(negedge pclk);
    chk({31'h0, irq}, 32'h0);
    wr(ADDR_IRQ_MASK, 32'h7);
    wait_irq();
    rdchk(ADDR_IRQ_STATUS, 32'h1 << IRQ_COMPLETE);
    wr(ADDR_IRQ_STATUS, 32'h1 << IRQ_COMPLETE);
    rdchk(ADDR_IRQ_STATUS, 32'h0);
    rdchk(ADDR_CONDITION, 32'h1 << FLAG_DONE);
    rdchk(ADDR_CONDITION, 32'h0);
    for (i = 6; i < 8; i++)
    begin
      wr(ADDR_COMMAND, i);
      wait_irq();
      rdchk(ADDR_IRQ_STATUS, 32'h1 << IRQ_ABORT);
      rdchk(ADDR_CONDITION, 32'h1 << FLAG_PROGRAM_ERR);
      repeat (3) @(negedge pclk);
      chk({31'h0, irq}, 32'h0);
    end
    for (i = 0; i < 4; i++)
    begin
      cyl = 8'($urandom_range(0, 255));
      wr(ADDR_COMMAND, 32'(OP_SEEK) | (i << CMD_DRIVE_LSB) | (32'(cyl) << CMD_CYL_LSB));
      repeat (20) @(negedge pclk);
      chk(32'(seek_sel), 32'h1 << i);
      chk(32'(seek_cyl), 32'(cyl));
      @(posedge pclk);
      drive_seek_done <= 1'b1;
      repeat (6) @(posedge pclk);
      drive_seek_done <= 1'b0;
      wait_irq();
      rdchk(ADDR_IRQ_STATUS, 32'h1 << IRQ_SEEK_DONE);
      wr(ADDR_IRQ_STATUS, 32'h7);
      apb(1'b0, ADDR_CONDITION, 32'h0);
    end
    base = 16'($urandom_range(0, 200));
    w0 = 16'($urandom);
    w1 = 16'($urandom);
    wr(ADDR_MEM_ADDR, 32'(base));
    wr(ADDR_WORD_COUNT, 32'h2);
    wr(ADDR_COMMAND, 32'(OP_READ));
    i = n_seek;
    fork
      begin
        send_word(w0);
        send_word(w1);
      end
      begin
        wr(ADDR_COMMAND, 32'(OP_SEEK));
        wr(ADDR_WORD_COUNT, 32'h5);
      end
    join
    wait_irq();
    chk(32'(mem_i.mem[base[7:0]]), 32'(w0));
    chk(32'(mem_i.mem[base[7:0] + 8'h1]), 32'(w1));
    chk(n_seek, i);
    rdchk(ADDR_WORD_COUNT, 32'h0);
    rdchk(ADDR_MEM_ADDR, 32'(base) + 32'h2);
    rdchk(ADDR_CONDITION, 32'h1 << FLAG_DONE);
    foreach (ops[j])
    begin
      base = 16'($urandom_range(0, 200));
      wr(ADDR_MEM_ADDR, 32'(base));
      wr(ADDR_WORD_COUNT, 32'h1);
      wr(ADDR_COMMAND, 32'(ops[j]));
      // let the first fetch land before the first bit
      repeat (10) @(posedge pclk);
      send_word(mem_i.mem[base[7:0]]);
      if (ops[j] != OP_VERIFY)
        chk(32'(wbits), 32'(mem_i.mem[base[7:0]]));
      wait_irq();
      chk(32'(last_fetch), 32'(base));
      rdchk(ADDR_WORD_COUNT, 32'h0);
      rdchk(ADDR_CONDITION, 32'h1 << FLAG_DONE);
    end
    wr(ADDR_IRQ_MASK, 32'h0);
    repeat (4) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    final_report();
  end
endmodule : disk_controller_bench
`default_nettype wire

// ---- verification/disk_ctrl_props.sv ----
// port checks of the disk controller
`timescale 1ns/1ps
`default_nettype none
module disk_ctrl_props
  import disk_ctrl_pkg::*;
  #(parameter int NUM_DRIVES = 4)
  (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [31:0] prdata, // apb read data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic irq, // interrupt
  input wire dma_req_s dma_req, // dma request
  input wire dma_rsp_s dma_rsp, // dma answer
  input wire logic [NUM_DRIVES-1:0] drive_select, // drive selects
  input wire logic drive_seek // seek strobe
  );
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_wait_a: assert property (psel && !penable |=> pready)
    else $error("pready not in first access cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_zero_a: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0)
    else $error("refused read not zero");
  dma_hold_a: assert property (dma_req.req && !dma_rsp.ack |=> dma_req.req && $stable(dma_req.addr) && $stable(dma_req.wr))
    else $error("dma request changed before ack");
  dma_drop_a: assert property (dma_req.req && dma_rsp.ack |=> !dma_req.req)
    else $error("dma request not dropped after ack");
  select_hot_a: assert property ($onehot0(drive_select))
    else $error("more than one drive selected");
  seek_select_a: assert property (drive_seek |-> $onehot(drive_select) ##1 !drive_seek)
    else $error("seek strobe malformed");
  irq_masked_a: assert property (psel && penable && pready && pwrite && paddr == ADDR_IRQ_MASK && pwdata[2:0] == 3'h0 |=> ##1 !irq)
    else $error("irq high with all masked");
  cover property (dma_rsp.ack && dma_req.wr);
  cover property (dma_rsp.ack && !dma_req.wr);
  cover property (drive_seek);
  cover property ($rose(irq));
endmodule : disk_ctrl_props
bind disk_controller disk_ctrl_props #(.NUM_DRIVES(NUM_DRIVES)) props_i (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
  .dma_req(dma_req), .dma_rsp(dma_rsp), .drive_select(drive_select), .drive_seek(drive_seek));
`default_nettype wire

// ---- verification/host_mem_model.sv ----
// host memory answering dma cycles with random latency
`timescale 1ns/1ps
`default_nettype none
module host_mem_model
  import disk_ctrl_pkg::*;
  (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire dma_req_s dma_req, // request
  output dma_rsp_s dma_rsp, // answer
  output logic [15:0] last_fetch // latest fetch address
  );
  logic [15:0] mem [0:255];
  logic [2:0] wait_cnt;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      dma_rsp <= '0;
      wait_cnt <= 3'h0;
      last_fetch <= 16'h0000;
      for (int i = 0; i < 256; i++)
        mem[i] <= 16'hA5A5 ^ i[15:0];
    end
    else if (dma_req.req && !dma_rsp.ack && wait_cnt == 3'h0)
    begin
      dma_rsp.ack <= 1'b1;
      wait_cnt <= 3'($urandom_range(0, 4));
      if (dma_req.wr)
        mem[dma_req.addr[7:0]] <= dma_req.wdata;
      else
      begin
        dma_rsp.rdata <= mem[dma_req.addr[7:0]];
        last_fetch <= dma_req.addr;
      end
    end
    else
    begin
      // stale data never looks valid
      dma_rsp.ack <= 1'b0;
      dma_rsp.rdata <= ~dma_rsp.rdata;
      if (dma_req.req && wait_cnt != 3'h0)
        wait_cnt <= wait_cnt - 3'h1;
    end
endmodule : host_mem_model
`default_nettype wire
